// ---- design/sbs_pkg.sv ----
// Shared constants and types for the synchronous burst memory control port.
// Assumes every user imports the whole package.
package sbs_pkg;

   // Data lane layout: eight data bits plus one parity bit per lane
   localparam int LANES       = 4;
   localparam int LANE_DATA_W = 8;
   localparam int LANE_W      = LANE_DATA_W + 1;
   localparam int WORD_W      = LANES * LANE_W;
   localparam int DATA_W      = LANES * LANE_DATA_W;

   // Address layout: burst counter owns the low bits only
   localparam int BURST_W     = 2;
   localparam int ADDR_W_DEF  = 10;

   // Reset values
   localparam logic               STRAP_RST  = 1'b1;
   localparam logic [BURST_W-1:0] BURST_RST  = 2'h0;
   localparam logic [1:0]         SETTLE_RST = 2'h0;

   // Edges the strap needs to cross its synchroniser before it is caught
   localparam logic [1:0]         STRAP_SETTLE = 2'h2;

   // Kind of access held in each pipeline stage
   typedef enum logic [1:0] {
      OP_IDLE,
      OP_READ,
      OP_WRITE
   } sbs_op_t;

endpackage

// ---- design/sbs_burst_step.sv ----
// Burst address stepper for the two low address bits.
// Assumes load and advance come qualified by the clock qualifier already.
`timescale 1ns/1ps
`default_nettype none

module sbs_burst_step
   import sbs_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // Control
   input  wire logic               load_i,
   input  wire logic               advance_i,
   input  wire logic               interleave_i,
   // Address
   input  wire logic [BURST_W-1:0] start_i,
   output logic      [BURST_W-1:0] addr_low_o
);

   logic [BURST_W-1:0] base;
   logic [BURST_W-1:0] count;
   logic [BURST_W-1:0] next_base;
   logic [BURST_W-1:0] next_count;
   logic [BURST_W-1:0] step;

   // Interleaved order flips bits, linear order adds and wraps in four
   function automatic logic [BURST_W-1:0] burst_addr(input logic [BURST_W-1:0] b,
                                                     input logic [BURST_W-1:0] off,
                                                     input logic               ilv);
      return ilv ? (b ^ off) : BURST_W'(b + off);
   endfunction

   assign step = BURST_W'(count + 1'b1);

   always_comb begin
      next_base  = base;
      next_count = count;
      if (load_i) begin
         next_base  = start_i;
         next_count = BURST_RST;
      end else if (advance_i) begin
         next_count = step;
      end
   end

   // Only the low bits move; the rest of the address is held by the caller
   always_comb begin
      addr_low_o = load_i ? start_i : burst_addr(base, step, interleave_i);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         base  <= BURST_RST;
         count <= BURST_RST;
      end else begin
         base  <= next_base;
         count <= next_count;
      end
   end

endmodule

`default_nettype wire

// ---- design/sbs_ctrl_port.sv ----
// Control port of a pipelined burst memory: select decode, lane-masked late
// writes, load or burst advance, and a clock qualifier that freezes all state but the strap capture.
// Assumes the master runs on clk_i; only the burst-order strap is asynchronous.
//
// How it works
// - The address is captured on the rising edge and picks one memory word for the access.
// - A lane write select is active low and only counts together with a low write strobe on a load, or in a write burst advance.
// - Each lane select gates exactly its own eight data bits and its own parity bit.
// - The write strobe is sampled only on an edge where the clock qualifier is low.
// - Advance high with the qualifier low steps the burst counter and ignores the address.
// - Advance low loads the external address for a new access.
// - An edge with the qualifier high has no effect on any synchronous input.
// - The first chip select is active low and takes part in selection.
// - The second chip select is active high and takes part in selection.
// - The port is selected only with the first and third selects low and the second high.
// - A high qualifier does not deselect; it freezes all state but the strap capture and stretches the cycle.
// - Data and parity are not driven in a write data phase, after deselection or deselected.
// - The burst-order strap picks interleaved when high and linear when low, held static.
`timescale 1ns/1ps
`default_nettype none

module sbs_ctrl_port
   import sbs_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
)
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Address and access control
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              write_strobe_n_i,
   input  wire logic              advance_or_load_i,
   input  wire logic              clock_qualifier_n_i,
   // Chip selects
   input  wire logic              select_low_first_i,
   input  wire logic              select_high_i,
   input  wire logic              select_low_third_i,
   // Lane write selects
   input  wire logic              lane_a_write_sel_n_i,
   input  wire logic              lane_b_write_sel_n_i,
   input  wire logic              lane_c_write_sel_n_i,
   input  wire logic              lane_d_write_sel_n_i,
   // Static strap
   input  wire logic              burst_order_strap_i,
   // Data pins
   input  wire logic [DATA_W-1:0] lane_data_i,
   output logic      [DATA_W-1:0] lane_data_o,
   output logic                   lane_data_oe_o,
   // Parity pins
   input  wire logic [LANES-1:0]  lane_parity_i,
   output logic      [LANES-1:0]  lane_parity_o,
   output logic                   lane_parity_oe_o
);

   localparam int DEPTH = 1 << ADDR_W;

   logic [WORD_W-1:0] mem [DEPTH];

   // Selection decode and write mask
   function automatic logic sel_decode(input logic ce1_n,
                                       input logic ce2,
                                       input logic ce3_n);
      return !ce1_n && ce2 && !ce3_n;
   endfunction

   function automatic logic [LANES-1:0] lane_mask(input logic             we_n,
                                                  input logic [LANES-1:0] bw_n);
      return we_n ? '0 : ~bw_n;
   endfunction

   logic [LANES-1:0]  bw_n;
   logic              run;
   logic              load;
   logic              adv;
   logic              sel;
   logic [BURST_W-1:0] burst_low;

   assign bw_n = {lane_d_write_sel_n_i, lane_c_write_sel_n_i,
                  lane_b_write_sel_n_i, lane_a_write_sel_n_i};
   assign run  = !clock_qualifier_n_i;
   assign load = run && !advance_or_load_i;
   assign adv  = run && advance_or_load_i;
   assign sel  = sel_decode(select_low_first_i, select_high_i, select_low_third_i);

   // Strap capture
   // The strap is asynchronous; it is synchronised, then caught once after reset
   // so a later wiggle cannot reorder a burst in flight.
   logic       strap_meta;
   logic       strap_sync;
   logic       interleave;
   logic [1:0] settle;
   logic       next_interleave;
   logic [1:0] next_settle;

   always_comb begin
      next_interleave = interleave;
      next_settle     = settle;
      if (settle <= STRAP_SETTLE) begin
         next_settle = 2'(settle + 1'b1);
      end
      // Caught one edge after the second flop holds the pin, not its reset value
      if (settle == STRAP_SETTLE) begin
         next_interleave = strap_sync;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         strap_meta <= STRAP_RST;
         strap_sync <= STRAP_RST;
         interleave <= STRAP_RST;
         settle     <= SETTLE_RST;
      end else begin
         strap_meta <= burst_order_strap_i;
         strap_sync <= strap_meta;
         interleave <= next_interleave;
         settle     <= next_settle;
      end
   end

   // Burst counter
   sbs_burst_step u_burst (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .load_i       (load),
      .advance_i    (adv),
      .interleave_i (interleave),
      .start_i      (addr_i[BURST_W-1:0]),
      .addr_low_o   (burst_low)
   );

   // Access pipeline
   // Stage 1 holds the access taken at the last edge, stage 2 the one before;
   // write data lands with stage 2, two accepted edges after its address.
   sbs_op_t           s1_op;
   sbs_op_t           s2_op;
   logic [ADDR_W-1:0] s1_addr;
   logic [ADDR_W-1:0] s2_addr;
   logic [LANES-1:0]  s1_mask;
   logic [LANES-1:0]  s2_mask;
   sbs_op_t           next_s1_op;
   sbs_op_t           next_s2_op;
   logic [ADDR_W-1:0] next_s1_addr;
   logic [ADDR_W-1:0] next_s2_addr;
   logic [LANES-1:0]  next_s1_mask;
   logic [LANES-1:0]  next_s2_mask;

   always_comb begin
      next_s1_op   = s1_op;
      next_s1_addr = s1_addr;
      next_s1_mask = s1_mask;
      next_s2_op   = s2_op;
      next_s2_addr = s2_addr;
      next_s2_mask = s2_mask;
      if (run) begin
         next_s2_op   = s1_op;
         next_s2_addr = s1_addr;
         next_s2_mask = s1_mask;
         if (load) begin
            next_s1_addr = {addr_i[ADDR_W-1:BURST_W], burst_low};
            case (sel)
               1'b0: begin
                  next_s1_op   = OP_IDLE;
                  next_s1_mask = '0;
               end
               default: begin
                  next_s1_op   = write_strobe_n_i ? OP_READ : OP_WRITE;
                  next_s1_mask = lane_mask(write_strobe_n_i, bw_n);
               end
            endcase
         end else begin
            // A burst keeps its kind and its upper address bits
            next_s1_addr = {s1_addr[ADDR_W-1:BURST_W], burst_low};
            next_s1_mask = lane_mask(s1_op != OP_WRITE, bw_n);
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_op   <= OP_IDLE;
         s1_addr <= '0;
         s1_mask <= '0;
         s2_op   <= OP_IDLE;
         s2_addr <= '0;
         s2_mask <= '0;
      end else begin
         s1_op   <= next_s1_op;
         s1_addr <= next_s1_addr;
         s1_mask <= next_s1_mask;
         s2_op   <= next_s2_op;
         s2_addr <= next_s2_addr;
         s2_mask <= next_s2_mask;
      end
   end

   // Storage
   logic [WORD_W-1:0] wr_word;

   always_comb begin
      wr_word = '0;
      for (int l = 0; l < LANES; l++) begin
         wr_word[l*LANE_W +: LANE_W] = {lane_parity_i[l],
                                        lane_data_i[l*LANE_DATA_W +: LANE_DATA_W]};
      end
   end

   // No bypass: a read issued one cycle after a write to the same word sees the
   // old contents, a trade for a shorter read path.
   always_ff @(posedge clk_i) begin
      if (run && s2_op == OP_WRITE) begin
         for (int l = 0; l < LANES; l++) begin
            if (s2_mask[l]) begin
               mem[s2_addr][l*LANE_W +: LANE_W] <= wr_word[l*LANE_W +: LANE_W];
            end
         end
      end
   end

   // Read data and drive control
   logic [WORD_W-1:0] rd_word;
   logic              drive;
   logic [WORD_W-1:0] next_rd_word;
   logic              next_drive;

   always_comb begin
      next_rd_word = rd_word;
      next_drive   = drive;
      if (run) begin
         next_rd_word = mem[s1_addr];
         // Only a read drives, so write data, deselect and the cycle after it float
         next_drive   = (s1_op == OP_READ);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_word <= '0;
         drive   <= 1'b0;
      end else begin
         rd_word <= next_rd_word;
         drive   <= next_drive;
      end
   end

   always_comb begin
      for (int l = 0; l < LANES; l++) begin
         lane_data_o[l*LANE_DATA_W +: LANE_DATA_W] = rd_word[l*LANE_W +: LANE_DATA_W];
         lane_parity_o[l] = rd_word[l*LANE_W + LANE_DATA_W];
      end
   end

   assign lane_data_oe_o   = drive;
   assign lane_parity_oe_o = drive;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence seq_load;
      !clock_qualifier_n_i && !advance_or_load_i;
   endsequence

   sequence seq_advance;
      !clock_qualifier_n_i && advance_or_load_i;
   endsequence

   sequence seq_frozen;
      clock_qualifier_n_i;
   endsequence

   a_freeze_state: assert property (seq_frozen |=> $stable(s1_op) && $stable(s1_addr)
         && $stable(s2_op) && $stable(drive))
      else $error("state moved while the clock qualifier was high");

   a_write_start: assert property (seq_load ##0 (sel && !write_strobe_n_i)
         |=> s1_op == OP_WRITE ##1 ($past(clock_qualifier_n_i) || s2_op == OP_WRITE))
      else $error("selected load with low strobe did not start a write");

   a_read_start: assert property (seq_load ##0 (sel && write_strobe_n_i)
         |=> s1_op == OP_READ && s1_mask == '0)
      else $error("selected load with high strobe did not start a read");

   a_deselect: assert property (seq_load ##0 !sel |=> s1_op == OP_IDLE)
      else $error("unselected load did not idle the port");

   a_load_addr: assert property (seq_load |=> s1_addr == $past(addr_i))
      else $error("loaded address differs from the address pins");

   a_advance_keeps: assert property (seq_advance |=> s1_op == $past(s1_op)
         && s1_addr[ADDR_W-1:BURST_W] == $past(s1_addr[ADDR_W-1:BURST_W]))
      else $error("advance changed the access kind or upper address");

   a_linear_step: assert property (seq_advance ##0 !interleave
         |=> s1_addr[BURST_W-1:0] == BURST_W'($past(s1_addr[BURST_W-1:0]) + 1'b1))
      else $error("linear burst did not step by one");

   a_write_mask: assert property (seq_load ##0 (sel && !write_strobe_n_i)
         |=> s1_mask == ~$past(bw_n))
      else $error("write lane mask does not follow the lane selects");

   a_no_drive_write: assert property (s2_op == OP_WRITE |-> !lane_data_oe_o)
      else $error("data driven during a write data phase");

   a_drive_read: assert property (!clock_qualifier_n_i && s1_op == OP_READ
         |=> lane_data_oe_o && lane_parity_oe_o ##1 (!$past(clock_qualifier_n_i) || lane_data_oe_o))
      else $error("read data was not driven in its data cycle");

endmodule

`default_nettype wire

// ---- dv/sbs_master_model.sv ----
// Model of the memory controller that drives the control port.
// Assumes a free-running clk_i; every issue call starts on a falling edge.
`timescale 1ns/1ps
`default_nettype none

module sbs_master_model
   import sbs_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
)
(
   // Clock
   input  wire logic              clk_i,
   // Control towards the port
   output logic      [ADDR_W-1:0] addr_o,
   output logic                   write_strobe_n_o,
   output logic                   advance_or_load_o,
   output logic                   clock_qualifier_n_o,
   output logic      [2:0]        select_o,
   output logic      [LANES-1:0]  lane_sel_n_o,
   // Write data, lane l is bits 8l+7:8l and parity bit l
   output logic      [DATA_W-1:0] lane_data_o,
   output logic      [LANES-1:0]  lane_parity_o
);
   logic              cur_wr;
   logic              p1_wr;
   logic              p2_wr;
   logic [WORD_W-1:0] cur_w;
   logic [WORD_W-1:0] p1_w;
   logic [WORD_W-1:0] p2_w;

   initial begin
      {addr_o, advance_or_load_o, clock_qualifier_n_o, select_o} = '0;
      {lane_sel_n_o, lane_data_o, lane_parity_o} = '0;
      {cur_wr, p1_wr, p2_wr, cur_w, p1_w, p2_w} = '0;
      write_strobe_n_o = 1'b1;
   end

   // Write data follows its address by two accepted edges; held edges do not count
   always @(posedge clk_i) begin
      if (!clock_qualifier_n_o) begin
         {p2_wr, p2_w, p1_wr, p1_w} <= {p1_wr, p1_w, cur_wr, cur_w};
      end
   end

   // No pull on the data lines, so an idle bus toggles instead of holding old data
   always @(negedge clk_i) begin
      if (p2_wr) begin
         {lane_parity_o, lane_data_o} <= p2_w;
      end else begin
         {lane_parity_o, lane_data_o} <= ~{lane_parity_o, lane_data_o};
      end
   end

   // One request per call, held for a whole clock
   task automatic issue(input logic wr, input logic [2:0] cs, input logic adv,
                        input logic [ADDR_W-1:0] a, input logic [3:0] bw_n,
                        input logic [WORD_W-1:0] w, input logic hold);
      select_o            = cs;
      write_strobe_n_o    = ~wr;
      advance_or_load_o   = adv;
      addr_o              = a;
      lane_sel_n_o        = bw_n;
      clock_qualifier_n_o = hold;
      cur_wr              = wr && (cs == 3'b010);
      cur_w               = w;
      @(negedge clk_i);
   endtask
endmodule

`default_nettype wire

// ---- dv/sbs_ctrl_port_tb.sv ----
// Self-checking bench for the control port of the burst memory.
// Assumes the master model as far side; strap changes only under reset.
`timescale 1ns/1ps
`default_nettype none

module sbs_ctrl_port_tb
   import sbs_pkg::*;
;
   localparam logic [2:0] SEL = 3'b010;
   localparam logic [2:0] OFF = 3'b110;
   localparam logic [9:0] A   = 10'h155;
   localparam logic [9:0] B   = 10'h3F0;

   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              strap = 1'b1;
   logic [9:0]        addr;
   logic              we_n, adv, cen_n;
   logic [2:0]        cs;
   logic [LANES-1:0]  bw_n, pin, pout;
   logic [DATA_W-1:0] din, dout;
   logic              doe, poe;
   int                n_mismatch = 0;
   int                checks_done = 0;

   always #50 clk_i = ~clk_i;

   sbs_ctrl_port #(.ADDR_W(10)) i_sbs_ctrl_port (.clk_i(clk_i), .rst_i(rst_i),
      .addr_i(addr), .write_strobe_n_i(we_n), .advance_or_load_i(adv),
      .clock_qualifier_n_i(cen_n), .select_low_first_i(cs[2]), .select_high_i(cs[1]),
      .select_low_third_i(cs[0]), .lane_a_write_sel_n_i(bw_n[0]),
      .lane_b_write_sel_n_i(bw_n[1]), .lane_c_write_sel_n_i(bw_n[2]),
      .lane_d_write_sel_n_i(bw_n[3]), .burst_order_strap_i(strap), .lane_data_i(din),
      .lane_data_o(dout), .lane_data_oe_o(doe), .lane_parity_i(pin),
      .lane_parity_o(pout), .lane_parity_oe_o(poe));

   sbs_master_model #(.ADDR_W(10)) i_sbs_master_model (.clk_i(clk_i), .addr_o(addr),
      .write_strobe_n_o(we_n), .advance_or_load_o(adv), .clock_qualifier_n_o(cen_n),
      .select_o(cs), .lane_sel_n_o(bw_n), .lane_data_o(din), .lane_parity_o(pin));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk1(input string nm, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %b seen %b", nm, exp, got);
      end
   endtask

   task automatic chkw(input string nm, input logic [WORD_W-1:0] exp,
                       input logic [WORD_W-1:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic go(input logic wr, input logic [2:0] c, input logic ad,
                     input logic [9:0] a, input logic [3:0] bw, input logic [WORD_W-1:0] w,
                     input logic hold = 1'b0);
      i_sbs_master_model.issue(wr, c, ad, a, bw, w, hold);
   endtask

   task automatic seen(input logic oe, input logic [WORD_W-1:0] w);
      chk1("data_oe", oe, doe);
      chk1("parity_oe", oe, poe);
      if (oe) begin
         chkw("read_word", w, {pout, dout});
      end
   endtask

   // Lane selects set low on reads must not write anything
   task automatic rd(input logic [9:0] a, input logic [WORD_W-1:0] exp);
      go(1'b0, SEL, 1'b0, a, 4'h0, '0);
      go(1'b0, OFF, 1'b0, a, 4'h0, '0);
      seen(1'b1, exp);
   endtask

   task automatic wr(input logic [9:0] a, input logic [3:0] bw, input logic [WORD_W-1:0] w);
      go(1'b1, SEL, 1'b0, a, bw, w);
      go(1'b0, OFF, 1'b0, a, 4'h0, '0);
      go(1'b0, OFF, 1'b0, a, 4'h0, '0);
   endtask

   function automatic logic [1:0] ord(input logic [1:0] b, input logic [1:0] k,
                                      input logic ilv);
      return ilv ? (b ^ k) : (b + k);
   endfunction

   function automatic logic [WORD_W-1:0] pat(input logic [3:0] l);
      return 36'hA5C3F0E10 ^ {9{l}};
   endfunction

   task automatic do_reset(input logic s);
      rst_i = 1'b1;
      strap = s;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      seen(1'b0, '0);
      repeat (3) @(negedge clk_i);
   endtask

   task automatic s_lanes();
      logic [WORD_W-1:0] exp;
      exp = 36'h9_1234_5678;
      wr(A, 4'h0, exp);
      rd(A, exp);
      for (int l = 0; l < 4; l++) begin
         wr(A, ~(4'h1 << l), 36'hF_FFFF_FFFF);
         exp = exp | ({4'h0, 32'hFF} << (8 * l)) | (36'h1 << (32 + l));
         rd(A, exp);
      end
   endtask

   task automatic s_select();
      for (int c = 0; c < 8; c++) begin
         go(1'b0, 3'(c), 1'b0, A, 4'h0, '0);
         go(1'b0, OFF, 1'b0, A, 4'h0, '0);
         seen(3'(c) == SEL, 36'hF_FFFF_FFFF);
      end
   endtask

   // A selected write offered on held edges must be ignored entirely
   task automatic s_freeze();
      go(1'b0, SEL, 1'b0, A, 4'h0, '0);
      repeat (3) begin
         go(1'b1, SEL, 1'b0, A, 4'h0, '0, 1'b1);
         seen(1'b0, '0);
      end
      go(1'b0, OFF, 1'b0, A, 4'h0, '0);
      seen(1'b1, 36'hF_FFFF_FFFF);
      go(1'b1, SEL, 1'b0, A, 4'h0, '0, 1'b1);
      seen(1'b1, 36'hF_FFFF_FFFF);
      go(1'b0, OFF, 1'b0, A, 4'h0, '0);
      rd(A, 36'hF_FFFF_FFFF);
   endtask

   // Burst write from low bits 2, burst read from low bits 1, junk address on advances
   task automatic s_burst(input logic ilv);
      for (int k = 0; k < 4; k++) begin
         go(1'b1, SEL, k != 0, (k == 0) ? (B | 10'h2) : 10'h0, 4'h0,
            pat({2'h0, ord(2'h2, 2'(k), ilv)}));
      end
      go(1'b0, OFF, 1'b0, B, 4'h0, '0);
      go(1'b0, OFF, 1'b0, B, 4'h0, '0);
      for (int k = 0; k < 5; k++) begin
         go(1'b0, (k < 4) ? SEL : OFF, k inside {1, 2, 3}, (k == 0) ? (B | 10'h1) : 10'h0,
            4'h0, '0);
         if (k > 0) begin
            seen(1'b1, pat({2'h0, ord(2'h1, 2'(k - 1), ilv)}));
         end
      end
   endtask

   initial begin
      #1_000_000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      @(negedge clk_i);
      do_reset(1'b1);
      s_lanes();
      s_select();
      s_freeze();
      s_burst(1'b1);
      do_reset(1'b0);
      s_burst(1'b0);
      end_sim();
   end
endmodule

`default_nettype wire
